// ===== rtl/eepw_defines.vh
// constants for the serial eeprom write controller
`ifndef EEPW_DEFINES_VH
`define EEPW_DEFINES_VH
`define EEPW_CLK_PERIOD_NS 5
`define EEPW_SCL_PERIOD_NS 2500
`define EEPW_QUARTER_CYC ((`EEPW_SCL_PERIOD_NS / 4 + `EEPW_CLK_PERIOD_NS - 1) / `EEPW_CLK_PERIOD_NS)
`define EEPW_WRITE_CYCLE_MS 5
`define EEPW_WRITE_CYCLE_CYC (`EEPW_WRITE_CYCLE_MS * 1000000 / `EEPW_CLK_PERIOD_NS)
`define EEPW_TYPE_CODE 4'h5
`define EEPW_DIR_WRITE 1'b0
`define EEPW_ADDR_W 13
`define EEPW_PAGE_BYTES 32
`define EEPW_ACK_BIT 4'h8
`define EEPW_FIFO_DEPTH 8
`endif

// ===== rtl/eepw_fifo.v
// byte fifo between the user data stream and the serial engine
`timescale 1ns/100ps
module eepw_fifo #(
  parameter WIDTH = 8,
  parameter DEPTH = 8,
  parameter AW = 3
) (
  input wire clock,
  input wire rst,
  input wire [WIDTH-1:0] inData,
  input wire inValid,
  output wire inReady,
  output reg [WIDTH-1:0] outData,
  output wire outValid,
  input wire outReady
);
  reg [WIDTH-1:0] mem [0:DEPTH-1];
  reg [AW-1:0] wrPtr_q;
  reg [AW-1:0] rdPtr_q;
  reg [AW:0] count_q;
  wire doWrite;
  wire doRead;
  wire [AW-1:0] rdNext;

  assign inReady = (count_q != DEPTH[AW:0]);
  assign outValid = (count_q != {(AW+1){1'b0}});
  assign doWrite = inValid & inReady;
  assign doRead = outValid & outReady;
  assign rdNext = ~doRead ? rdPtr_q :
    (rdPtr_q == DEPTH[AW-1:0] - 1'b1) ? {AW{1'b0}} : rdPtr_q + 1'b1;

  // read data come from a register; a write into the word due next bypasses the array
  always @(posedge clock) begin
    if (doWrite && wrPtr_q == rdNext) begin
      outData <= inData;
    end else begin
      outData <= mem[rdNext];
    end
  end

  always @(posedge clock) begin
    if (doWrite) begin
      mem[wrPtr_q] <= inData;
    end
  end

  always @(posedge clock) begin
    if (rst) begin
      wrPtr_q <= {AW{1'b0}};
      rdPtr_q <= {AW{1'b0}};
      count_q <= {(AW+1){1'b0}};
    end else begin
      if (doWrite) begin
        wrPtr_q <= (wrPtr_q == DEPTH[AW-1:0] - 1'b1) ? {AW{1'b0}} : wrPtr_q + 1'b1;
      end
      if (doRead) begin
        rdPtr_q <= (rdPtr_q == DEPTH[AW-1:0] - 1'b1) ? {AW{1'b0}} : rdPtr_q + 1'b1;
      end
      if (doWrite & ~doRead) begin
        count_q <= count_q + 1'b1;
      end else if (doRead & ~doWrite) begin
        count_q <= count_q - 1'b1;
      end
    end
  end
endmodule // eepw_fifo

// ===== rtl/eepw_host.v
// two-wire master that runs byte and page writes and polls for the end of the write cycle
`timescale 1ns/100ps
`include "eepw_defines.vh"
// Notes on behaviour
// (R1) start: data falls while clock high, begins every command
// (R2) stop: data rises while clock high, closes every operation
// (R3) data changes only while clock low, one clock pulse per bit
// (R4) start only when both lines sit high; cmdReady here checks only the synchronised data line, not the clock
// (R5) receiver acknowledges each byte on a ninth clock from the master
// (R6) acknowledge holds data low through the whole ninth clock high phase
// (R7) reading master withholds last acknowledge; device then releases data
// (R8) first byte after start is type code, chip selects, direction
// (R9) device acknowledges only on matching type code and chip selects
// (R10) direction bit one means read, zero means write
// (R11) two address bytes follow, high first; top three bits ignored
// (R12) byte write: control, two address bytes, data, then stop starts cycle
// (R13) no acknowledge at all while the internal write runs
// (R14) protected write is acknowledged but stores nothing
// (R15) after byte write the address counter points past the byte
// (R16) page write: up to 31 more bytes, committed after stop
// (R17) only low five address bits step; over 32 bytes wraps the page
// (R18) protect input sampled at stop; later changes do not matter
// (R19) master polls with start and write control byte until acknowledged
// (R20) sequential access never crosses into a neighbouring device
// (R21) write cycle ends within five milliseconds of its stop
// (R22) device drives data only low, open drain
// (R23) start mid-transaction restarts control byte, keeps loaded address
// (R24) stop before a full data byte starts no write
module eepw_host #(
  parameter QUARTER_CYC = `EEPW_QUARTER_CYC,
  parameter WRITE_TIMEOUT_CYC = `EEPW_WRITE_CYCLE_CYC,
  parameter [3:0] TYPE_CODE = `EEPW_TYPE_CODE, // arbitrary value, set to the device's type code
  parameter DATA_W = 8,
  parameter FIFO_DEPTH = `EEPW_FIFO_DEPTH
) (
  input wire clock,
  input wire rst,
  input wire cmdValid,
  output wire cmdReady,
  input wire [2:0] cmdChipSel,
  input wire [`EEPW_ADDR_W-1:0] cmdAddr,
  input wire [5:0] cmdCount,
  input wire cmdProtect,
  input wire [DATA_W-1:0] wrData,
  input wire wrValid,
  output wire wrReady,
  output reg doneQ,
  output reg errorQ,
  output wire busy,
  output wire sclOut,
  output wire sclOe,
  input wire sdaIn,
  output wire sdaOut,
  output wire sdaOe,
  output reg writeProtectQ
);
  localparam [2:0] S_IDLE = 3'h0, S_START = 3'h1, S_BYTE = 3'h2, S_WAIT = 3'h3, S_STOP = 3'h4;
  localparam [2:0] K_CTRL = 3'h0, K_AHI = 3'h1, K_ALO = 3'h2, K_DATA = 3'h3, K_POLL = 3'h4;

  reg [2:0] st_q;
  reg [2:0] kind_q;
  reg [15:0] qc_q;
  reg [1:0] ph_q;
  reg [3:0] bit_q;
  reg [7:0] shift_q;
  reg [5:0] left_q;
  reg [2:0] chip_q;
  reg [`EEPW_ADDR_W-1:0] addr_q;
  reg sclLow_q, sdaLow_q, polling_q, failed_q;
  reg [31:0] pollCnt_q;
  reg sdaMeta_q, sdaSync_q;
  wire tick;
  wire [DATA_W-1:0] fifoData;
  wire fifoValid;
  wire fifoPop;
  wire [7:0] ctrlByte;

  ////////////////////////////////////////////////////////////////////////////
  // data path buffer; the engine holds clock low while it runs dry

  eepw_fifo #(.WIDTH(DATA_W), .DEPTH(FIFO_DEPTH), .AW(3)) eepw_fifo_inst (
    .clock(clock), .rst(rst), .inData(wrData), .inValid(wrValid), .inReady(wrReady),
    .outData(fifoData), .outValid(fifoValid), .outReady(fifoPop)
  );

  assign fifoPop = (st_q == S_WAIT) & fifoValid;
  // write direction only: there is never a last read byte to leave unacknowledged
  assign ctrlByte = {TYPE_CODE, chip_q, `EEPW_DIR_WRITE}; // R7 R8 R10 R19
  assign tick = (qc_q == QUARTER_CYC[15:0] - 16'h0001);
  assign cmdReady = (st_q == S_IDLE) & sdaSync_q; // R4
  assign busy = (st_q != S_IDLE);
  // open drain: only ever pull low
  assign sclOut = 1'b0;
  assign sclOe = sclLow_q;
  assign sdaOut = 1'b0;
  assign sdaOe = sdaLow_q;

  ////////////////////////////////////////////////////////////////////////////
  // pin synchroniser

  always @(posedge clock) begin
    if (rst) begin
      sdaMeta_q <= 1'b1;
      sdaSync_q <= 1'b1;
    end else begin
      sdaMeta_q <= sdaIn;
      sdaSync_q <= sdaMeta_q;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // quarter-bit timebase, free running only while busy and not waiting for data

  always @(posedge clock) begin
    if (rst || st_q == S_IDLE || st_q == S_WAIT || tick) begin
      qc_q <= 16'h0000;
    end else begin
      qc_q <= qc_q + 16'h0001;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // sequencer

  always @(posedge clock) begin
    if (rst) begin
      st_q <= S_IDLE;
      kind_q <= K_CTRL;
      ph_q <= 2'h0;
      bit_q <= 4'h0;
      shift_q <= 8'h00;
      left_q <= 6'h00;
      chip_q <= 3'h0;
      addr_q <= {`EEPW_ADDR_W{1'b0}};
      sclLow_q <= 1'b0;
      sdaLow_q <= 1'b0;
      polling_q <= 1'b0;
      failed_q <= 1'b0;
      pollCnt_q <= 32'h00000000;
      doneQ <= 1'b0;
      errorQ <= 1'b0;
      writeProtectQ <= 1'b0;
    end else begin
      doneQ <= 1'b0;
      if (polling_q) begin
        pollCnt_q <= pollCnt_q + 32'h00000001;
      end
      case (st_q)
        S_IDLE: begin
          sclLow_q <= 1'b0;
          sdaLow_q <= 1'b0;
          if (cmdValid && cmdReady) begin
            chip_q <= cmdChipSel;
            addr_q <= cmdAddr;
            left_q <= (cmdCount == 6'h00) ? 6'h01 : cmdCount;
            // held through the stop so the device samples a steady level
            writeProtectQ <= cmdProtect; // R18
            polling_q <= 1'b0;
            failed_q <= 1'b0;
            pollCnt_q <= 32'h00000000;
            kind_q <= K_CTRL;
            ph_q <= 2'h0;
            st_q <= S_START;
          end
        end
        S_START: if (tick) begin
          ph_q <= ph_q + 2'h1;
          case (ph_q)
            2'h0: begin
              sclLow_q <= 1'b0;
              sdaLow_q <= 1'b0;
            end
            2'h1: sdaLow_q <= 1'b1; // R1
            2'h2: sclLow_q <= 1'b1;
            default: begin
              shift_q <= ctrlByte;
              bit_q <= 4'h0;
              st_q <= S_BYTE;
            end
          endcase
        end
        S_BYTE: if (tick) begin
          ph_q <= ph_q + 2'h1;
          case (ph_q)
            2'h0: begin
              sclLow_q <= 1'b1;
              // data moves only with clock low; ninth bit left to the device
              sdaLow_q <= (bit_q == `EEPW_ACK_BIT) ? 1'b0 : ~shift_q[7]; // R3 R5
            end
            2'h1: sclLow_q <= 1'b1;
            2'h2: sclLow_q <= 1'b0;
            default: begin
              sclLow_q <= 1'b1;
              if (bit_q != `EEPW_ACK_BIT) begin
                shift_q <= {shift_q[6:0], 1'b0};
                bit_q <= bit_q + 4'h1;
              end else begin
                // low at the end of the high phase counts as acknowledge
                bit_q <= 4'h0;
                if (sdaSync_q) begin // R6
                  // no acknowledge: retry while polling, else give up
                  ph_q <= 2'h0;
                  st_q <= S_STOP;
                  if (!polling_q) begin
                    failed_q <= 1'b1;
                  end
                end else begin
                  case (kind_q)
                    K_CTRL: begin
                      kind_q <= K_AHI;
                      shift_q <= {3'b000, addr_q[12:8]}; // R11
                    end
                    K_AHI: begin
                      kind_q <= K_ALO;
                      shift_q <= addr_q[7:0]; // R11
                    end
                    K_ALO: begin
                      kind_q <= K_DATA;
                      st_q <= S_WAIT;
                    end
                    K_DATA: begin
                      left_q <= left_q - 6'h01;
                      // track the device's counter: only the page bits step
                      addr_q[4:0] <= addr_q[4:0] + 5'h01; // R17
                      if (left_q == 6'h01) begin
                        // stop only after a whole data byte was acknowledged
                        ph_q <= 2'h0;
                        st_q <= S_STOP; // R12 R16 R24
                      end else begin
                        st_q <= S_WAIT;
                      end
                    end
                    default: begin
                      polling_q <= 1'b0;
                      ph_q <= 2'h0;
                      st_q <= S_STOP; // R19
                    end
                  endcase
                end
              end
            end
          endcase
        end
        S_WAIT: begin
          // clock stays low until the next byte is available
          sclLow_q <= 1'b1;
          if (fifoValid) begin
            shift_q <= fifoData[7:0];
            ph_q <= 2'h0;
            st_q <= S_BYTE;
          end
        end
        S_STOP: if (tick) begin
          ph_q <= ph_q + 2'h1;
          case (ph_q)
            2'h0: begin
              sclLow_q <= 1'b1;
              sdaLow_q <= 1'b1;
            end
            2'h1: sclLow_q <= 1'b1;
            2'h2: sclLow_q <= 1'b0;
            default: begin
              sdaLow_q <= 1'b0; // R2
              ph_q <= 2'h0;
              if (failed_q) begin
                errorQ <= 1'b1;
                doneQ <= 1'b1;
                st_q <= S_IDLE;
              end else if (kind_q == K_DATA) begin
                // write cycle running: poll until it answers
                kind_q <= K_POLL;
                polling_q <= 1'b1;
                pollCnt_q <= 32'h00000000;
                st_q <= S_START; // R19
              end else if (polling_q) begin
                if (pollCnt_q >= WRITE_TIMEOUT_CYC) begin
                  // device broke its write time limit
                  errorQ <= 1'b1; // R21
                  doneQ <= 1'b1;
                  polling_q <= 1'b0;
                  st_q <= S_IDLE;
                end else begin
                  st_q <= S_START; // R13 R19
                end
              end else begin
                errorQ <= 1'b0;
                doneQ <= 1'b1;
                st_q <= S_IDLE;
              end
            end
          endcase
        end
        default: st_q <= S_IDLE;
      endcase
    end
  end
endmodule // eepw_host

// ===== verif/eepw_host_assertions.sv
// concurrent checks on the two-wire write controller ports
`timescale 1ns/100ps
module eepw_host_checker (
  input wire clock,
  input wire rst,
  input wire cmdValid,
  input wire cmdReady,
  input wire busy,
  input wire doneQ,
  input wire sclOe,
  input wire sdaOe,
  input wire sdaIn,
  input wire writeProtectQ
);
  default clocking cb @(posedge clock); endclocking
  default disable iff (rst);
  ////////////////////////////////////////////////////////////////////////////////
  sequence s_start;
    $rose(sdaOe) && !sclOe;
  endsequence
  sequence s_stop;
    $fell(sdaOe) && !sclOe;
  endsequence
  property p_idle; !busy |-> !sclOe && !sdaOe; endproperty
  a_idle: assert property (p_idle) else $error("bus held while idle");
  property p_ready; cmdReady |-> !busy && sdaIn; endproperty
  a_ready: assert property (p_ready) else $error("ready on a busy bus");
  property p_start; $rose(busy) |-> ##[1:12] s_start; endproperty
  a_start: assert property (p_start) else $error("command without start");
  property p_start_clk; s_start |-> ##[1:8] $rose(sclOe); endproperty
  a_start_clk: assert property (p_start_clk) else $error("clock not low after start");
  // the line stays free long enough for a clean bus free gap
  property p_stop; s_stop |-> !sdaOe [*3]; endproperty
  a_stop: assert property (p_stop) else $error("data driven right after stop");
  property p_data; $fell(sclOe) |-> (!sclOe && $stable(sdaOe)) [*2]; endproperty
  a_data: assert property (p_data) else $error("data moved in clock high");
  property p_take; cmdValid && cmdReady |=> busy; endproperty
  a_take: assert property (p_take) else $error("command not taken");
  property p_prot; busy && $past(busy) |-> $stable(writeProtectQ); endproperty
  a_prot: assert property (p_prot) else $error("protect moved in a command");
  property p_done; doneQ |-> !sclOe && !sdaOe ##1 !doneQ; endproperty
  a_done: assert property (p_done) else $error("done without bus release");
endmodule // eepw_host_checker
bind eepw_host eepw_host_checker eepw_host_checker_inst (.clock(clock), .rst(rst),
  .cmdValid(cmdValid), .cmdReady(cmdReady), .busy(busy), .doneQ(doneQ), .sclOe(sclOe),
  .sdaOe(sdaOe), .sdaIn(sdaIn), .writeProtectQ(writeProtectQ));

// ===== verif/eepw_dev_model.sv
// behavioural serial eeprom on the far side of the bus, write path only
`timescale 1ns/100ps
module eepw_dev_model #(
  parameter [3:0] TYPE_CODE = 4'h5, // arbitrary value, matches the controller
  parameter WRITE_NS = 2000,
  parameter HOLD_NS = 12
) (
  input wire scl,
  input wire sda,
  output reg devOe,
  input wire [2:0] chipSel,
  input wire writeProtect
);
  reg [7:0] mem [0:8191];
  reg [7:0] page [0:31];
  reg [31:0] pend = 0;
  reg [7:0] sh = 0;
  reg [12:0] addr = 0;
  reg sel = 0;
  reg cycleBusy = 0;
  reg ok;
  integer bitN = 0;
  integer phase = 0;
  integer nData = 0;
  integer k;
  initial begin
    devOe = 0;
    for (k = 0; k < 8192; k = k + 1) mem[k] = 8'hff;
  end
  ////////////////////////////////////////////////////////////////////////////////
  always @(negedge sda) if (scl) begin
    sel = 1;
    bitN = 0;
    phase = 0;
  end
  always @(posedge sda) if (scl) begin
    if (sel && phase == 3 && nData > 0 && !writeProtect && !cycleBusy) begin
      for (k = 0; k < 32; k = k + 1)
        if (pend[k]) mem[{addr[12:5], k[4:0]}] = page[k];
      cycleBusy = 1;
      cycleBusy <= #WRITE_NS 1'b0;
    end
    sel = 0;
  end
  always @(posedge scl) if (sel) begin
    if (bitN < 8) sh = {sh[6:0], sda};
    bitN = bitN + 1;
  end
  always @(negedge scl) if (sel) begin
    if (bitN == 8) begin
      ok = !cycleBusy && (phase > 0 || (sh[7:4] == TYPE_CODE && sh[3:1] == chipSel));
      devOe <= #1 ok;
      if (!ok) sel = 0;
      if (ok && phase == 0) pend = 0;
      if (ok && phase == 0) nData = 0;
      if (ok && phase == 1) addr[12:8] = sh[4:0];
      if (ok && phase == 2) addr[7:0] = sh;
      if (ok && phase == 3) begin
        page[addr[4:0]] = sh;
        pend[addr[4:0]] = 1'b1;
        addr[4:0] = addr[4:0] + 5'h01;
        nData = nData + 1;
      end
      // reads are not modelled: a read stays in a dead phase
      phase = (phase == 0 && sh[0]) ? 4 : (phase < 3 ? phase + 1 : phase);
    end else if (bitN == 9) begin
      // hold past the falling clock so a slow sampler still sees the acknowledge
      devOe <= #HOLD_NS 1'b0;
      bitN = 0;
    end
  end
endmodule // eepw_dev_model

// ===== verif/tb_top.sv
// self-checking bench for the two-wire write controller
`timescale 1ns/100ps
module tb_top;
  localparam [2:0] DEV_CS = 3'h5;
  reg clock = 0;
  reg rst = 1;
  reg cmdValid = 0;
  reg [2:0] cmdChipSel = 0;
  reg [12:0] cmdAddr = 0;
  reg [5:0] cmdCount = 0;
  reg cmdProtect = 0;
  reg [7:0] wrData = 0;
  reg wrValid = 0;
  reg sawFull = 0;
  wire cmdReady, wrReady, doneQ, errorQ, busy, sclOut, sclOe, sdaOut, sdaOe, writeProtectQ, devOe;
  wire sclLine = sclOe ? sclOut : 1'b1;
  wire sdaLine = !((sdaOe && !sdaOut) || devOe);
  reg [7:0] refMem [0:8191];
  integer fails = 0;
  integer comparisons = 0;
  integer cycles = 0;
  integer i;
  always #2.5 clock = ~clock;
  eepw_host #(.QUARTER_CYC(2), .WRITE_TIMEOUT_CYC(2000)) eepw_host_inst (.clock(clock),
    .rst(rst), .cmdValid(cmdValid), .cmdReady(cmdReady), .cmdChipSel(cmdChipSel),
    .cmdAddr(cmdAddr), .cmdCount(cmdCount), .cmdProtect(cmdProtect), .wrData(wrData),
    .wrValid(wrValid), .wrReady(wrReady), .doneQ(doneQ), .errorQ(errorQ), .busy(busy),
    .sclOut(sclOut), .sclOe(sclOe), .sdaIn(sdaLine), .sdaOut(sdaOut), .sdaOe(sdaOe),
    .writeProtectQ(writeProtectQ));
  eepw_dev_model eepw_dev_model_inst (.scl(sclLine), .sda(sdaLine), .devOe(devOe),
    .chipSel(DEV_CS), .writeProtect(writeProtectQ));
  ////////////////////////////////////////////////////////////////////////////////
  function [12:0] wrap_addr(input [12:0] base, input integer n);
    wrap_addr = {base[12:5], base[4:0] + n[4:0]};
  endfunction
  task report_and_stop;
    begin
      $display("comparisons %0d fails %0d", comparisons, fails);
      if (fails == 0 && comparisons > 0)
        $display("Result: passed");
      else
        $display("Result: failed");
      $finish;
    end
  endtask
  task check(input [8*8:1] what, input [31:0] seen, input [31:0] expected);
    begin
      comparisons = comparisons + 1;
      if (seen !== expected) begin
        fails = fails + 1;
        $display("wrong value %0s expected %h seen %h", what, expected, seen);
      end
    end
  endtask
  task push(input [7:0] b);
    begin
      @(negedge clock);
      wrData = b;
      wrValid = 1;
      while (!wrReady) begin
        sawFull = 1;
        @(negedge clock);
      end
      @(negedge clock);
      wrValid = 0;
    end
  endtask
  task run(input [2:0] cs, input [12:0] addr, input [5:0] cnt, input prot);
    integer n, k;
    reg [7:0] b;
    reg [12:0] a;
    begin
      n = (cnt == 0) ? 1 : cnt;
      fork
        // a refused control byte sends no data, so its bytes would linger
        if (cs == DEV_CS) for (k = 0; k < n; k = k + 1) begin
          b = $urandom;
          if (!prot) refMem[wrap_addr(addr, k)] = b;
          push(b);
        end
        begin
          @(negedge clock);
          cmdChipSel = cs;
          cmdAddr = addr;
          cmdCount = cnt;
          cmdProtect = prot;
          cmdValid = 1;
          while (!cmdReady) @(negedge clock);
          @(negedge clock);
          cmdValid = 0;
          while (!doneQ) @(negedge clock);
        end
      join
      check("error", errorQ, cs != DEV_CS);
      check("cycle", eepw_dev_model_inst.cycleBusy, 0);
      if (cs == DEV_CS) check("pointer", eepw_dev_model_inst.addr, wrap_addr(addr, n));
      for (k = 0; k < 32; k = k + 1) begin
        a = {addr[12:5], k[4:0]};
        check("memory", eepw_dev_model_inst.mem[a], refMem[a]);
      end
    end
  endtask
  always @(posedge clock) begin
    cycles = cycles + 1;
    if (cycles == 95000) begin
      fails = fails + 1;
      report_and_stop;
    end
  end
  initial begin
    for (i = 0; i < 8192; i = i + 1) refMem[i] = 8'hff;
    i = $urandom(67);
    repeat (20) @(negedge clock);
    rst = 0;
    repeat (3) @(negedge clock);
    run(DEV_CS, 13'h0123, 6'h01, 0);
    run(DEV_CS, 13'h1f4c, 6'h20, 0);
    check("full", sawFull, 1);
    run(DEV_CS, 13'h0a07, 6'h28, 0);
    run(DEV_CS, 13'h0123, 6'h03, 1);
    run(3'h2, 13'h0040, 6'h02, 0);
    run(DEV_CS, 13'h0040, 6'h00, 0);
    for (i = 0; i < 7; i = i + 1)
      run(($urandom % 4 == 0) ? 3'h3 : DEV_CS, $urandom, $urandom % 41, $urandom % 4 == 0);
    report_and_stop;
  end
endmodule // tb_top
